// [lpmc_ctrl.sv]
// Low power mode controller: wait/stop entry, gating, wake and recovery
`timescale 1ns/1ns
module lpmc_ctrl #(
  parameter int REC_LONG = lpmc_pkg::LPMC_REC_LONG,
  parameter int REC_SHORT = lpmc_pkg::LPMC_REC_SHORT,
  parameter int WDOG_TIMEOUT = lpmc_pkg::LPMC_WDOG_TIMEOUT
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reference clock tick (oscillator, synchronous)
  input wire logic ref_tick,
  // Wake requests from peripherals, already enable-gated
  input wire lpmc_pkg::lpmc_wake_t wake_req,
  // Supply monitor trip
  input wire logic svm_trip,
  // Clock gates
  output lpmc_pkg::lpmc_clk_t clk_gate,
  // Per-peripheral mode indications
  output lpmc_pkg::lpmc_mode_t mode_adc,
  output lpmc_pkg::lpmc_mode_t mode_brk,
  output lpmc_pkg::lpmc_mode_t mode_sci,
  output lpmc_pkg::lpmc_mode_t mode_spi,
  output lpmc_pkg::lpmc_mode_t mode_tim,
  output lpmc_pkg::lpmc_mode_t mode_tbm,
  // Peripheral side effects
  output logic adc_abort,
  output logic spi_reset,
  output logic integ_cnt_clear,
  output logic wdog_ref_en,
  // Processor interrupt mask and system reset request
  output logic cpu_irq_mask,
  output logic sys_reset_req
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  lpmc_pkg::lpmc_state_t state_ff, nxt_state;
  logic [3:0] cfg1_ff;
  logic [0:0] cfg2_ff;
  logic [1:0] mask_ff;
  logic [0:0] wdog_en_ff;
  logic cpu_mask_ff;
  logic stop_refused_ff;
  logic reset_wake_ff;
  logic [31:0] prdata_ff;
  logic [$clog2(WDOG_TIMEOUT+1)-1:0] wdog_cnt_ff;
  logic sys_rst_ff;

  logic wr_en, rd_en, addr_ok;
  logic cmd_wait, cmd_stop;
  logic osc_run, in_wait, in_stop, in_rec;
  logic wake_wait, wake_stop, rec_start, rec_busy, rec_done;
  logic wdog_service, wdog_timeout;

  // ------------------------------------------------------------------
  // APB decode; zero wait states, so each access ends in one cycle
  // ------------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && clk_en;
  assign rd_en = psel && penable && !pwrite && clk_en;
  always_comb begin
    unique case (paddr)
      lpmc_pkg::LPMC_CFG1_OFS, lpmc_pkg::LPMC_CFG2_OFS, lpmc_pkg::LPMC_CMD_OFS,
      lpmc_pkg::LPMC_STAT_OFS, lpmc_pkg::LPMC_MASK_OFS,
      lpmc_pkg::LPMC_WDOG_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  // Unmapped addresses answer with an error, writes dropped
  assign pslverr = psel && penable && !addr_ok;

  assign cmd_wait = wr_en && paddr == lpmc_pkg::LPMC_CMD_OFS
                    && pwdata[lpmc_pkg::LPMC_CMD_WAIT];
  assign cmd_stop = wr_en && paddr == lpmc_pkg::LPMC_CMD_OFS
                    && pwdata[lpmc_pkg::LPMC_CMD_STOP] && !pwdata[lpmc_pkg::LPMC_CMD_WAIT];
  assign wdog_service = wr_en && paddr == lpmc_pkg::LPMC_WDOG_OFS
                        && pwdata[lpmc_pkg::LPMC_WDOG_SERVICE];

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  // Config writes are accepted in every mode; only clk_en low blocks them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg1_ff <= lpmc_pkg::LPMC_CFG1_RST;
      cfg2_ff <= lpmc_pkg::LPMC_CFG2_RST;
      mask_ff <= lpmc_pkg::LPMC_MASK_RST;
      wdog_en_ff <= lpmc_pkg::LPMC_WDOG_RST;
    end else if (wr_en) begin
      if (paddr == lpmc_pkg::LPMC_CFG1_OFS) cfg1_ff <= pwdata[3:0];
      if (paddr == lpmc_pkg::LPMC_CFG2_OFS) cfg2_ff <= pwdata[0:0];
      if (paddr == lpmc_pkg::LPMC_MASK_OFS) mask_ff <= pwdata[1:0];
      if (paddr == lpmc_pkg::LPMC_WDOG_OFS) wdog_en_ff <= pwdata[0:0];
    end
  end

  assign osc_run = cfg2_ff[lpmc_pkg::LPMC_CFG2_OSC_RUN];

  // ------------------------------------------------------------------
  // Wake qualification
  // ------------------------------------------------------------------
  assign wake_wait = wake_req.adc || wake_req.brk || wake_req.clock_generator_unit
                     || (wake_req.ext && !mask_ff[lpmc_pkg::LPMC_MASK_EXT])
                     || (wake_req.kbd && !mask_ff[lpmc_pkg::LPMC_MASK_KBD])
                     || wake_req.sci || wake_req.spi || wake_req.tim
                     || wake_req.periodic_tick_unit;
  // In stop only external pins, break and tick (with oscillator) can wake
  assign wake_stop = (wake_req.ext && !mask_ff[lpmc_pkg::LPMC_MASK_EXT])
                     || (wake_req.kbd && !mask_ff[lpmc_pkg::LPMC_MASK_KBD])
                     || wake_req.brk
                     || (wake_req.periodic_tick_unit && osc_run);

  // ------------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      lpmc_pkg::LPMC_RUN: begin
        if (cmd_wait) nxt_state = lpmc_pkg::LPMC_WAIT;
        else if (cmd_stop && cfg1_ff[lpmc_pkg::LPMC_CFG1_STOP_EN])
          nxt_state = lpmc_pkg::LPMC_STOP;
      end
      lpmc_pkg::LPMC_WAIT: if (wake_wait) nxt_state = lpmc_pkg::LPMC_RUN;
      lpmc_pkg::LPMC_STOP: if (wake_stop || sys_rst_ff) nxt_state = lpmc_pkg::LPMC_RECOVER;
      lpmc_pkg::LPMC_RECOVER: if (rec_done) nxt_state = lpmc_pkg::LPMC_RUN;
    endcase
    // A system reset request pulls run or wait back to run; stop and recovery go on through recovery
    if (sys_rst_ff && state_ff != lpmc_pkg::LPMC_STOP
        && state_ff != lpmc_pkg::LPMC_RECOVER) nxt_state = lpmc_pkg::LPMC_RUN;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_ff <= lpmc_pkg::LPMC_RUN;
    else if (clk_en) state_ff <= nxt_state;
  end

  assign in_wait = state_ff == lpmc_pkg::LPMC_WAIT;
  assign in_stop = state_ff == lpmc_pkg::LPMC_STOP;
  assign in_rec = state_ff == lpmc_pkg::LPMC_RECOVER;
  assign rec_start = in_stop && nxt_state == lpmc_pkg::LPMC_RECOVER;

  // Remember whether stop was left by reset, for serial abort
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) reset_wake_ff <= 1'b0;
    else if (clk_en && rec_start) reset_wake_ff <= sys_rst_ff;
  end

  // Stop recovery timing on reference ticks
  lpmc_recovery #(
    .LONG_CYC(REC_LONG),
    .SHORT_CYC(REC_SHORT)
  ) u_rec (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .start(rec_start),
    .short_sel(cfg1_ff[lpmc_pkg::LPMC_CFG1_SHORT_RECOVERY_SELECT]),
    .ref_tick(ref_tick),
    .busy(rec_busy),
    .done(rec_done)
  );

  // ------------------------------------------------------------------
  // Processor interrupt mask
  // ------------------------------------------------------------------
  // Mask set by reset, cleared on entry; interrupt exit leaves it clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cpu_mask_ff <= 1'b1;
    else if (clk_en) begin
      if (sys_rst_ff) cpu_mask_ff <= 1'b1;
      else if (state_ff == lpmc_pkg::LPMC_RUN && nxt_state != lpmc_pkg::LPMC_RUN)
        cpu_mask_ff <= 1'b0;
      else if (wr_en && paddr == lpmc_pkg::LPMC_MASK_OFS)
        cpu_mask_ff <= pwdata[lpmc_pkg::LPMC_MASK_CPU];
    end
  end

  // Sticky note that a stop instruction was refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stop_refused_ff <= 1'b0;
    else if (clk_en) begin
      if (cmd_stop && !cfg1_ff[lpmc_pkg::LPMC_CFG1_STOP_EN]) stop_refused_ff <= 1'b1;
      else if (rd_en && paddr == lpmc_pkg::LPMC_STAT_OFS) stop_refused_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Watchdog: counts except in stop (cleared) and recovery (held), reference removed in stop
  // ------------------------------------------------------------------
  assign wdog_timeout = wdog_cnt_ff == ($bits(wdog_cnt_ff))'(WDOG_TIMEOUT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wdog_cnt_ff <= '0;
    else if (clk_en) begin
      if (wdog_service || in_stop || sys_rst_ff) wdog_cnt_ff <= '0;
      else if (wdog_en_ff[0] && ref_tick && !in_rec && !wdog_timeout)
        wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
    end
  end

  // One-cycle system reset request: watchdog or supply monitor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sys_rst_ff <= 1'b0;
    else if (clk_en) begin
      sys_rst_ff <= (wdog_en_ff[0] && wdog_timeout && !sys_rst_ff)
                    || (svm_trip && cfg1_ff[lpmc_pkg::LPMC_CFG1_SVM_EN]
                        && cfg1_ff[lpmc_pkg::LPMC_CFG1_SVM_RST] && !sys_rst_ff);
    end
  end

  // ------------------------------------------------------------------
  // Read data, registered
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_ff <= '0;
    else if (clk_en && psel && !penable) begin
      unique case (paddr)
        lpmc_pkg::LPMC_CFG1_OFS: prdata_ff <= {28'h0000000, cfg1_ff};
        lpmc_pkg::LPMC_CFG2_OFS: prdata_ff <= {31'h0, cfg2_ff};
        lpmc_pkg::LPMC_STAT_OFS: prdata_ff <= {26'h0, rec_busy, reset_wake_ff,
                                               stop_refused_ff, cpu_mask_ff, state_ff};
        lpmc_pkg::LPMC_MASK_OFS: prdata_ff <= {29'h0, cpu_mask_ff, mask_ff};
        lpmc_pkg::LPMC_WDOG_OFS: prdata_ff <= {31'h0, wdog_en_ff};
        default: prdata_ff <= '0;
      endcase
    end
  end
  assign prdata = prdata_ff;

  // ------------------------------------------------------------------
  // Clock gating outputs
  // ------------------------------------------------------------------
  assign clk_gate.cpu_clk_en = !(in_wait || in_stop || in_rec);
  assign clk_gate.bus_clk_en = !((in_stop && !osc_run) || in_rec);
  assign clk_gate.osc_en = !(in_stop && !osc_run);
  assign clk_gate.pll_en = !in_stop;
  assign wdog_ref_en = !in_stop;
  assign integ_cnt_clear = in_stop;

  // ------------------------------------------------------------------
  // Peripheral mode indications; tick unit counts as running with osc
  // ------------------------------------------------------------------
  assign mode_adc = '{wait_active: in_wait, stop_active: in_stop};
  assign mode_brk = '{wait_active: in_wait, stop_active: in_stop};
  assign mode_sci = '{wait_active: in_wait, stop_active: in_stop};
  assign mode_spi = '{wait_active: in_wait, stop_active: in_stop};
  assign mode_tim = '{wait_active: in_wait, stop_active: in_stop};
  assign mode_tbm = '{wait_active: in_wait, stop_active: in_stop && !osc_run};

  assign adc_abort = rec_start || (state_ff == lpmc_pkg::LPMC_RUN
                     && nxt_state == lpmc_pkg::LPMC_STOP);
  assign spi_reset = in_rec && reset_wake_ff;
  assign cpu_irq_mask = cpu_mask_ff;
  assign sys_reset_req = sys_rst_ff;

endmodule // lpmc_ctrl

// [lpmc_ctrl_assertions.sv]
// Concurrent checks on the ports of the low power mode controller
`timescale 1ns/1ns
module lpmc_ctrl_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB status
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  // Mode, gating and side effects
  input wire lpmc_pkg::lpmc_clk_t clk_gate,
  input wire lpmc_pkg::lpmc_mode_t mode_adc,
  input wire logic adc_abort,
  input wire logic spi_reset,
  input wire logic integ_cnt_clear,
  input wire logic wdog_ref_en,
  input wire logic cpu_irq_mask,
  input wire logic sys_reset_req
);
  // One domain, so clock and reset are given once
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------------
  // Stop exit steps
  // ------------------------------------------------------------------
  sequence stop_exit_s;
    $fell(mode_adc.stop_active);
  endsequence
  sequence clocks_held_s;
    (!clk_gate.cpu_clk_en && !clk_gate.bus_clk_en) [*3];
  endsequence

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  wait_gating_a:
    assert property (mode_adc.wait_active |-> !clk_gate.cpu_clk_en && clk_gate.bus_clk_en)
    else $error("wait gating wrong");
  stop_gating_a:
    assert property (mode_adc.stop_active |-> !clk_gate.cpu_clk_en && !clk_gate.pll_en
      && clk_gate.bus_clk_en == clk_gate.osc_en) else $error("stop gating wrong");
  wait_unmask_a:
    assert property ($rose(mode_adc.wait_active) |-> !cpu_irq_mask)
    else $error("mask not cleared on wait");
  stop_unmask_a:
    assert property ($rose(mode_adc.stop_active) |-> !cpu_irq_mask)
    else $error("mask not cleared on stop");
  reset_mask_a:
    assert property (sys_reset_req |-> ##[0:2] cpu_irq_mask) else $error("mask not set on reset");
  recover_hold_a:
    assert property (stop_exit_s |-> clocks_held_s) else $error("clocks not held after stop");
  stop_counter_a:
    assert property (mode_adc.stop_active |-> integ_cnt_clear && !wdog_ref_en)
    else $error("watchdog reference not removed in stop");
  abort_entry_a:
    assert property ($rose(mode_adc.stop_active) |-> adc_abort || $past(adc_abort))
    else $error("no converter abort on stop");
  pulse_single_a:
    assert property (sys_reset_req |=> !sys_reset_req) else $error("reset request too long");
  spi_hold_a:
    assert property (spi_reset |-> !clk_gate.cpu_clk_en) else $error("spi reset outside recovery");
  mode_excl_a:
    assert property (!(mode_adc.wait_active && mode_adc.stop_active)) else $error("both modes");
  err_phase_a:
    assert property (pslverr |-> psel && penable) else $error("error outside access phase");
endmodule // lpmc_ctrl_chk

bind lpmc_ctrl lpmc_ctrl_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
  .clk_gate(clk_gate), .mode_adc(mode_adc), .adc_abort(adc_abort), .spi_reset(spi_reset),
  .integ_cnt_clear(integ_cnt_clear), .wdog_ref_en(wdog_ref_en),
  .cpu_irq_mask(cpu_irq_mask), .sys_reset_req(sys_reset_req)
);

// [lpmc_pkg.sv]
// Package for the low power mode controller: register map, fields, timing
package lpmc_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ------------------------------------------------------------------
  localparam logic [7:0] LPMC_CFG1_OFS = 8'h00;   // system_config_one
  localparam logic [7:0] LPMC_CFG2_OFS = 8'h04;   // system_config_two
  localparam logic [7:0] LPMC_CMD_OFS = 8'h08;    // instruction strobes
  localparam logic [7:0] LPMC_STAT_OFS = 8'h0C;   // mode and wake status
  localparam logic [7:0] LPMC_MASK_OFS = 8'h10;   // ext, kbd and processor interrupt masks
  localparam logic [7:0] LPMC_WDOG_OFS = 8'h14;   // watchdog control

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int LPMC_CFG1_STOP_EN = 0;
  localparam int LPMC_CFG1_SHORT_RECOVERY_SELECT = 1;
  localparam int LPMC_CFG1_SVM_EN = 2;
  localparam int LPMC_CFG1_SVM_RST = 3;
  localparam int LPMC_CFG2_OSC_RUN = 0;
  localparam int LPMC_CMD_WAIT = 0;
  localparam int LPMC_CMD_STOP = 1;
  localparam int LPMC_MASK_EXT = 0;
  localparam int LPMC_MASK_KBD = 1;
  localparam int LPMC_MASK_CPU = 2;
  localparam int LPMC_WDOG_EN = 0;
  localparam int LPMC_WDOG_SERVICE = 1;

  // Reset values
  localparam logic [3:0] LPMC_CFG1_RST = 4'h4;
  localparam logic [0:0] LPMC_CFG2_RST = 1'h0;
  localparam logic [1:0] LPMC_MASK_RST = 2'h0;
  localparam logic [0:0] LPMC_WDOG_RST = 1'h0;

  // ------------------------------------------------------------------
  // Timing: recovery in reference clock cycles
  // ------------------------------------------------------------------
  localparam int LPMC_REC_LONG = 4096;
  localparam int LPMC_REC_SHORT = 32;
  localparam int LPMC_REC_W = 12;
  localparam int LPMC_WDOG_TIMEOUT = 262144;

  // Controller state
  typedef enum logic [1:0] {
    LPMC_RUN,
    LPMC_WAIT,
    LPMC_STOP,
    LPMC_RECOVER
  } lpmc_state_t;

  // Per-peripheral mode indications
  typedef struct packed {
    logic wait_active;
    logic stop_active;
  } lpmc_mode_t;

  // Wake sources grouped
  typedef struct packed {
    logic adc;
    logic brk;
    logic clock_generator_unit;
    logic ext;
    logic kbd;
    logic sci;
    logic spi;
    logic tim;
    logic periodic_tick_unit;
  } lpmc_wake_t;

  // Clock gates driven out
  typedef struct packed {
    logic cpu_clk_en;
    logic bus_clk_en;
    logic osc_en;
    logic pll_en;
  } lpmc_clk_t;

endpackage

// [lpmc_recovery.sv]
// Stop recovery counter counting reference clock ticks
`timescale 1ns/1ns
module lpmc_recovery #(
  parameter int LONG_CYC = lpmc_pkg::LPMC_REC_LONG,
  parameter int SHORT_CYC = lpmc_pkg::LPMC_REC_SHORT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Control
  input wire logic start,
  input wire logic short_sel,
  input wire logic ref_tick,
  // Status
  output logic busy,
  output logic done
);

  localparam int CW = lpmc_pkg::LPMC_REC_W + 1;
  localparam logic [CW-1:0] LONG_V = CW'(LONG_CYC);
  localparam logic [CW-1:0] SHORT_V = CW'(SHORT_CYC);
  localparam logic [CW-1:0] ONE_V = CW'(1);

  logic [CW-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;

  // Load on start, decrement on each reference tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      done_ff <= 1'b0;
      if (start) begin
        cnt_ff <= short_sel ? SHORT_V : LONG_V;
        busy_ff <= 1'b1;
      end else if (busy_ff && ref_tick) begin
        cnt_ff <= cnt_ff - ONE_V;
        if (cnt_ff == ONE_V) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;

endmodule // lpmc_recovery

// [test_lpmc_ctrl.sv]
// Self-checking testbench for the low power mode controller
`timescale 1ns/1ns
module test_lpmc_ctrl;
  // ------------------------------------------------------------------
  // Signals, counters, shortened counts
  // ------------------------------------------------------------------
  localparam int REC_L = 16;
  localparam int REC_S = 4;
  localparam int WDOG_T = 64;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, r;
  logic pready, pslverr, adc_abort, spi_reset, integ_cnt_clear, wdog_ref_en;
  logic cpu_irq_mask, sys_reset_req, seen, e;
  logic svm_trip = 1'b0;
  logic clk_en = 1'b1;
  lpmc_pkg::lpmc_wake_t wake_req = 9'h000;
  lpmc_pkg::lpmc_clk_t clk_gate;
  lpmc_pkg::lpmc_mode_t mode_adc, mode_brk, mode_sci, mode_spi, mode_tim, mode_tbm;
  int n_errors = 0;
  int cmp_count = 0;
  int n_abort = 0;
  int n_rst = 0;
  int seed = 95;
  int i, n, src, na, nr;

  lpmc_ctrl #(.REC_LONG(REC_L), .REC_SHORT(REC_S), .WDOG_TIMEOUT(WDOG_T)) i_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_tick(1'b1), .wake_req(wake_req), .svm_trip(svm_trip),
    .clk_gate(clk_gate), .mode_adc(mode_adc), .mode_brk(mode_brk), .mode_sci(mode_sci),
    .mode_spi(mode_spi), .mode_tim(mode_tim), .mode_tbm(mode_tbm), .adc_abort(adc_abort),
    .spi_reset(spi_reset), .integ_cnt_clear(integ_cnt_clear), .wdog_ref_en(wdog_ref_en),
    .cpu_irq_mask(cpu_irq_mask), .sys_reset_req(sys_reset_req)
  );

  // Clock at 125 MHz
  initial begin
    forever #4 pclk = ~pclk;
  end

  // Pulse counters sampled on the clock, so single-cycle pulses are never missed
  always @(posedge pclk) begin
    if (adc_abort === 1'b1) n_abort++;
    if (sys_reset_req === 1'b1) n_rst++;
  end

  // ------------------------------------------------------------------
  // Bus tasks, expectations, comparisons
  // ------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No fixed latency assumed: wait for pready, the hang guard bounds it
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk_word(r & m, exp, "register read");
  endtask
  function automatic logic [31:0] exp_gate(input int st, input logic osc);
    lpmc_pkg::lpmc_clk_t g;
    g.cpu_clk_en = (st == 0);
    g.bus_clk_en = (st < 2) || osc;
    g.osc_en = (st != 2) || osc;
    g.pll_en = (st != 2);
    return {28'h0000000, g};
  endfunction
  function automatic int rec_len(input logic sh);
    return sh ? REC_S : REC_L;
  endfunction
  task automatic wait_run(input int lim);
    n = 0;
    seen = 1'b0;
    while (clk_gate.cpu_clk_en !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
      seen = seen | (spi_reset === 1'b1);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    give_verdict();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(lpmc_pkg::LPMC_CFG1_OFS, 32'h0000000F, 32'h00000004);
    rdc(lpmc_pkg::LPMC_CFG2_OFS, 32'h00000001, 32'h00000000);
    rdc(lpmc_pkg::LPMC_MASK_OFS, 32'h00000003, 32'h00000000);
    rdc(lpmc_pkg::LPMC_STAT_OFS, 32'h0000003F, 32'h00000004);
    rdc(8'h18, 32'hFFFFFFFF, 32'h00000000);
    chk_word({31'h0, e}, 32'h00000001, "unmapped error");
    $display("Test reset values done");
    // Wait entry and wake, first from the maskable sources, then random ones
    for (i = 0; i < 8; i++) begin
      src = (i < 2) ? 3 + i : $unsigned($random(seed)) % 9;
      apb(1'b1, lpmc_pkg::LPMC_MASK_OFS, 32'h00000007);
      apb(1'b1, lpmc_pkg::LPMC_CMD_OFS, 32'h00000001);
      cyc(2);
      chk_word({28'h0, clk_gate}, exp_gate(1, 1'b0), "wait gate");
      chk_word({mode_adc, mode_brk, mode_sci, mode_spi, mode_tim, mode_tbm}, 12'hAAA, "modes");
      chk_word({31'h0, cpu_irq_mask}, 32'h0, "wait mask");
      @(posedge pclk);
      wake_req <= 9'h100 >> src;
      if (src == 3 || src == 4) begin
        cyc(4);
        chk_word({31'h0, mode_adc.wait_active}, 32'h1, "masked wake");
        apb(1'b1, lpmc_pkg::LPMC_MASK_OFS, 32'h00000000);
      end
      cyc(3);
      @(posedge pclk);
      wake_req <= 9'h000;
      cyc(1);
      chk_word({28'h0, clk_gate}, exp_gate(0, 1'b0), "wake to run");
      chk_word({31'h0, cpu_irq_mask}, 32'h0, "mask after wake");
    end
    $display("Test wait wake done");
    // Stop in all four oscillator and recovery settings
    for (i = 0; i < 4; i++) begin
      apb(1'b1, lpmc_pkg::LPMC_MASK_OFS, 32'h00000005);
      apb(1'b1, lpmc_pkg::LPMC_CFG1_OFS, 32'h00000005 | ((i >> 1) << 1));
      apb(1'b1, lpmc_pkg::LPMC_CFG2_OFS, i & 1);
      na = n_abort;
      apb(1'b1, lpmc_pkg::LPMC_CMD_OFS, 32'h00000002);
      cyc(3);
      chk_word({28'h0, clk_gate}, exp_gate(2, i[0]), "stop gate");
      chk_word({mode_adc, mode_brk, mode_sci, mode_spi, mode_tim, mode_tbm},
               {10'h155, 1'b0, !i[0]}, "modes");
      chk_word({integ_cnt_clear, wdog_ref_en, cpu_irq_mask}, 3'h4, "stop effects");
      @(posedge pclk);
      wake_req <= 9'h16E | !i[0];
      cyc(4);
      chk_word({31'h0, mode_adc.stop_active}, 32'h1, "no wake");
      @(posedge pclk);
      wake_req <= i[0] ? 9'h001 : 9'h010;
      wait_run(200);
      chk_word({31'h0, n >= rec_len(i[1]) && n <= rec_len(i[1]) + 3}, 32'h1, "recovery");
      chk_word({31'h0, cpu_irq_mask}, 32'h0, "mask after stop");
      chk_word(n_abort - na, 32'h2, "converter aborts");
      @(posedge pclk);
      wake_req <= 9'h000;
    end
    $display("Test stop modes done");
    // Stop refused while its enable is clear
    apb(1'b1, lpmc_pkg::LPMC_CFG1_OFS, 32'h00000004);
    apb(1'b0, lpmc_pkg::LPMC_STAT_OFS, 32'h00000000);
    apb(1'b1, lpmc_pkg::LPMC_CMD_OFS, 32'h00000002);
    cyc(3);
    chk_word({28'h0, clk_gate}, exp_gate(0, 1'b0), "refused stop");
    rdc(lpmc_pkg::LPMC_STAT_OFS, 32'h00000008, 32'h00000008);
    rdc(lpmc_pkg::LPMC_STAT_OFS, 32'h00000008, 32'h00000000);
    // Clock enable low freezes all state, so a wait command is lost
    @(posedge pclk);
    clk_en <= 1'b0;
    apb(1'b1, lpmc_pkg::LPMC_CMD_OFS, 32'h00000001);
    cyc(3);
    chk_word({28'h0, clk_gate}, exp_gate(0, 1'b0), "frozen wait");
    @(posedge pclk);
    clk_en <= 1'b1;
    $display("Test refused stop done");
    // Supply monitor reset out of stop, then out of wait
    for (i = 0; i < 2; i++) begin
      apb(1'b1, lpmc_pkg::LPMC_CFG1_OFS, 32'h0000000D);
      apb(1'b1, lpmc_pkg::LPMC_CFG2_OFS, 32'h00000000);
      apb(1'b1, lpmc_pkg::LPMC_CMD_OFS, i ? 32'h1 : 32'h2);
      nr = n_rst;
      cyc(3);
      @(posedge pclk);
      svm_trip <= 1'b1;
      @(posedge pclk);
      svm_trip <= 1'b0;
      wait_run(200);
      cyc(2);
      chk_word({seen, cpu_irq_mask}, {!i[0], 1'b1}, "reset exit");
      chk_word({31'h0, n_rst > nr}, 32'h1, "monitor reset");
      chk_word({28'h0, clk_gate}, exp_gate(0, 1'b0), "run after reset");
    end
    $display("Test supply reset done");
    // Watchdog serviced in time, then left to expire in wait
    apb(1'b1, lpmc_pkg::LPMC_CFG1_OFS, 32'h00000004);
    apb(1'b1, lpmc_pkg::LPMC_WDOG_OFS, 32'h00000001);
    nr = n_rst;
    for (i = 0; i < 3; i++) begin
      cyc(WDOG_T - 20);
      apb(1'b1, lpmc_pkg::LPMC_WDOG_OFS, 32'h00000003);
    end
    chk_word(n_rst - nr, 32'h0, "serviced watchdog");
    apb(1'b1, lpmc_pkg::LPMC_CMD_OFS, 32'h00000001);
    n = 0;
    while (n_rst == nr && n < 300) begin
      cyc(1);
      n++;
    end
    chk_word({31'h0, n >= WDOG_T - 10 && n <= WDOG_T + 4}, 32'h1, "watchdog timeout");
    apb(1'b1, lpmc_pkg::LPMC_WDOG_OFS, 32'h00000000);
    chk_word({mode_adc.wait_active, cpu_irq_mask}, 2'h1, "watchdog exit");
    $display("Test watchdog done");
    give_verdict();
  end
endmodule // test_lpmc_ctrl
